// ===== inc/fmc_pkg.sv
// Summary of operation
// - Image and audio no-mark states are set independently from key message flags.
// - A commanded no-mark state holds for the whole composition it unlocks.
// - No-mark state carries over to the next composition unless new key message flags are written before it starts.
// - Image track records carry one image mark indicator, no audio indicator.
// - Audio track records carry one audio mark indicator, no image indicator.
// - Payload is at least 35 bits with time stamp and location fields.
// - Time stamp advances each quarter hour over a 366-day year, then wraps.
// - Time stamp field is 16 bits, covering all 35,136 values.
// - Location field is 19 bits, giving 524,288 identifiers.
// - The full 35-bit payload is embedded in every five-minute segment.
// - A 30-minute sample yields identification with two or three stamps.
// - Stamp and location are embedded in image and each of 16 channels.
// - Disabled audio marking passes samples bit-identical to the source.
// - Selective marking up to channel 6 leaves channels 7-16 bit-identical.
// - Unmarked audio is gap-free: no sample inserted, dropped or repeated.
// - Essence that was not encrypted is never marked.
// - Selective threshold N marks channels 1..N, leaves higher channels unmarked.
package fmc_pkg;

    // Clock and time base
    localparam longint unsigned CLK_HZ = 250_000_000;
    localparam longint unsigned QTR_HOUR_MIN = 15;
    localparam longint unsigned QTR_CYCLES = QTR_HOUR_MIN * 60 * CLK_HZ;
    localparam int QTR_W = 38;

    // Payload layout
    localparam int TS_W = 16;
    localparam int LOC_W = 19;
    localparam int PAY_W = TS_W + LOC_W;
    localparam int unsigned YEAR_DAYS = 366;
    localparam int unsigned TS_VALUES = YEAR_DAYS * 24 * 4;
    localparam logic [TS_W-1:0] TS_LAST = TS_W'(TS_VALUES - 1);
    localparam int BIT_W = 6;

    // Essence formats
    localparam int NCH = 16;
    localparam int CH_W = 4;
    localparam int SMP_W = 24;
    localparam int PIX_W = 12;
    localparam int NCOMP = 3;
    localparam logic [CH_W-1:0] CH_LAST = CH_W'(NCH - 1);

    // Segment pacing: whole payload inside one segment
    localparam int unsigned SEG_MIN = 5;
    localparam int unsigned FRAME_HZ = 24;
    localparam int unsigned SAMPLE_HZ = 48000;
    localparam int unsigned FRAMES_PER_BIT = SEG_MIN * 60 * FRAME_HZ / PAY_W;
    localparam int unsigned SAMPLES_PER_BIT = SEG_MIN * 60 * SAMPLE_HZ / PAY_W;
    localparam int UNIT_W = 20;

    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TIME = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LOC = 8'h0c;

    // Field positions
    localparam int CTRL_NM_IMG = 0;
    localparam int CTRL_NM_AUD = 1;
    localparam int CTRL_SEL = 2;
    localparam int CTRL_THR_LSB = 8;
    localparam int THR_W = 7;
    localparam int ST_IMG_ON = 0;
    localparam int ST_AUD_ON = 1;
    localparam int ST_IMG_BIT = 2;
    localparam int ST_AUD_BIT = 3;
    localparam int ST_THR_LSB = 8;

    // Reset values
    localparam logic [TS_W-1:0] TS_RST = 16'h0000;
    localparam logic [LOC_W-1:0] LOC_RST = 19'h00000;

    typedef struct packed {
        logic nm_img;
        logic nm_aud;
        logic sel;
        logic [THR_W-1:0] thr;
    } fmc_flags_t;

    localparam fmc_flags_t FLAGS_RST = '0;

    typedef struct packed {
        logic valid;
        logic encrypted;
        logic [CH_W-1:0] chan;
        logic [SMP_W-1:0] data;
    } fmc_aud_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic encrypted;
        logic [NCOMP*PIX_W-1:0] data;
    } fmc_pix_t;

    typedef struct packed {
        logic valid;
        logic is_image;
        logic img_present;
        logic img_mark;
        logic aud_present;
        logic aud_mark;
    } fmc_rec_t;

endpackage

// ===== verilog/fmc_symbol_seq.sv
`timescale 1ns/1ns
// Steps through the payload one bit per UNITS events, MSB first
module fmc_symbol_seq #(
    parameter int unsigned UNITS = 1
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic step,
    input wire logic [fmc_pkg::PAY_W-1:0] payload,
    output logic mark_bit
);
    import fmc_pkg::*;

    logic [UNIT_W-1:0] unit_cnt;
    logic [BIT_W-1:0] bit_idx;
    logic [PAY_W-1:0] snap;
    logic primed;

    wire unit_last = unit_cnt == UNIT_W'(UNITS - 1);
    wire bit_last = bit_idx == BIT_W'(PAY_W - 1);
    wire [BIT_W-1:0] sel_pos = BIT_W'(PAY_W - 1) - bit_idx;

    // Snapshot per pass so one segment never mixes two stamps
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            unit_cnt <= '0;
            bit_idx <= '0;
            snap <= '0;
            primed <= 1'b0;
        end else begin
            if (!primed) begin
                snap <= payload;
                primed <= 1'b1;
            end
            if (step) begin
                unit_cnt <= unit_last ? '0 : unit_cnt + 1'b1;
                if (unit_last) begin
                    bit_idx <= bit_last ? '0 : bit_idx + 1'b1;
                end
                if (unit_last && bit_last) begin
                    snap <= payload;
                end
            end
        end
    end

    // Registered bit keeps the marking path short
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mark_bit <= 1'b0;
        end else begin
            mark_bit <= snap[sel_pos];
        end
    end
endmodule

// ===== verilog/fmc_mark_ctrl.sv
`timescale 1ns/1ns
// Forensic mark control: enables, time stamp, payload, essence marking, log indicators
module fmc_mark_ctrl #(
    parameter longint unsigned QTR_CYCLES = fmc_pkg::QTR_CYCLES,
    parameter int unsigned SAMPLES_PER_BIT = fmc_pkg::SAMPLES_PER_BIT,
    parameter int unsigned FRAMES_PER_BIT = fmc_pkg::FRAMES_PER_BIT
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [fmc_pkg::ADDR_W-1:0] addr,
    input wire logic [fmc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fmc_pkg::DATA_W-1:0] rdata,
    input wire logic comp_start,
    input wire fmc_pkg::fmc_aud_t aud_in,
    output fmc_pkg::fmc_aud_t aud_out,
    input wire fmc_pkg::fmc_pix_t pix_in,
    output fmc_pkg::fmc_pix_t pix_out,
    input wire logic rec_req,
    input wire logic rec_image,
    input wire logic rec_encrypted,
    output fmc_pkg::fmc_rec_t rec_out
);
    import fmc_pkg::*;

    // Channel c (0-based) is marked when audio marking is on
    // and, under selective mode, c is below the threshold
    function automatic logic chan_marked(input fmc_flags_t f, input logic [CH_W-1:0] c);
        logic on;
        on = f.sel ? (f.thr != '0) : !f.nm_aud;
        chan_marked = on && (!f.sel || ({{(THR_W-CH_W){1'b0}}, c} < f.thr));
    endfunction

    // Staged flags from the key message, and the flags in force
    fmc_flags_t staged;
    fmc_flags_t active;
    fmc_flags_t next_active;

    logic [TS_W-1:0] stamp;
    logic [LOC_W-1:0] location;
    logic [QTR_W-1:0] qtr_cnt;

    // Register decode
    wire hit_ctrl = addr == REG_CTRL;
    wire hit_state = addr == REG_STATE;
    wire hit_time = addr == REG_TIME;
    wire hit_loc = addr == REG_LOC;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_time = wr && hit_time;
    wire wr_loc = wr && hit_loc;

    wire fmc_flags_t wflags = '{
        nm_img: wdata[CTRL_NM_IMG],
        nm_aud: wdata[CTRL_NM_AUD],
        sel: wdata[CTRL_SEL],
        thr: wdata[CTRL_THR_LSB +: THR_W]
    };

    // Key message flags are only staged; they never touch the running composition
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            staged <= FLAGS_RST;
        end else if (wr_ctrl) begin
            staged <= wflags;
        end
    end

    // New composition takes the staged flags in the very cycle of the boundary,
    // so its first frame and sample already see them
    assign next_active = comp_start ? staged : active;

    // Latched flags hold until the next boundary; nothing else can change them
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active <= FLAGS_RST;
        end else begin
            active <= next_active;
        end
    end

    // Effective enables, selective mode overrides a no-mark flag
    wire img_on = !next_active.nm_img;
    wire aud_on = next_active.sel ? (next_active.thr != '0) : !next_active.nm_aud;

    // Quarter-hour divider; long count is a parameter so simulation can shrink it
    wire qtr_tick = qtr_cnt == QTR_W'(QTR_CYCLES - 1);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            qtr_cnt <= '0;
        end else if (wr_time || qtr_tick) begin
            qtr_cnt <= '0;
        end else begin
            qtr_cnt <= qtr_cnt + 1'b1;
        end
    end

    // Stamp counts quarter hours of a 366-day year and wraps yearly;
    // software sets it from the secure clock, a write beats a tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stamp <= TS_RST;
        end else if (wr_time) begin
            stamp <= (wdata[TS_W-1:0] > TS_LAST) ? TS_RST : wdata[TS_W-1:0];
        end else if (qtr_tick) begin
            stamp <= (stamp == TS_LAST) ? TS_RST : stamp + 1'b1;
        end
    end

    // Location identifier of this device
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            location <= LOC_RST;
        end else if (wr_loc) begin
            location <= wdata[LOC_W-1:0];
        end
    end

    // Payload: stamp in the upper 16 bits, location in the lower 19
    wire [PAY_W-1:0] payload = {stamp, location};

    // Sequencers pace one payload pass per five-minute segment;
    // a new stamp every 15 min means a 30-min sample holds two or three
    wire img_step = pix_in.valid && pix_in.sof;
    wire aud_step = aud_in.valid && (aud_in.chan == CH_LAST);
    logic img_bit;
    logic aud_bit;

    fmc_symbol_seq #(
        .UNITS(FRAMES_PER_BIT)
    ) u_img_seq (
        .clock(clock),
        .arst_n(arst_n),
        .step(img_step),
        .payload(payload),
        .mark_bit(img_bit)
    );

    fmc_symbol_seq #(
        .UNITS(SAMPLES_PER_BIT)
    ) u_aud_seq (
        .clock(clock),
        .arst_n(arst_n),
        .step(aud_step),
        .payload(payload),
        .mark_bit(aud_bit)
    );

    // Audio marking decision per sample; plaintext is never touched
    wire aud_mark = aud_in.encrypted && chan_marked(next_active, aud_in.chan);
    wire [SMP_W-1:0] aud_mod = {aud_in.data[SMP_W-1:1], aud_in.data[0] ^ aud_bit};
    wire [SMP_W-1:0] aud_sel = aud_mark ? aud_mod : aud_in.data;

    // One sample in, one sample out, fixed one-cycle latency, no stall:
    // nothing can be inserted, dropped or repeated
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aud_out <= '0;
        end else begin
            aud_out.valid <= aud_in.valid;
            aud_out.encrypted <= aud_in.encrypted;
            aud_out.chan <= aud_in.chan;
            aud_out.data <= aud_sel;
        end
    end

    // Image marking on each colour component
    wire pix_mark = pix_in.encrypted && img_on;
    wire [NCOMP*PIX_W-1:0] pix_mod;

    // Same bit in every component keeps the mark through colour conversion
    for (genvar k = 0; k < NCOMP; k++) begin : g_comp
        assign pix_mod[k*PIX_W +: PIX_W] = {pix_in.data[k*PIX_W+1 +: PIX_W-1],
                                            pix_in.data[k*PIX_W] ^ img_bit};
    end

    wire [NCOMP*PIX_W-1:0] pix_sel = pix_mark ? pix_mod : pix_in.data;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pix_out <= '0;
        end else begin
            pix_out.valid <= pix_in.valid;
            pix_out.sof <= pix_in.sof;
            pix_out.encrypted <= pix_in.encrypted;
            pix_out.data <= pix_sel;
        end
    end

    // Log indicators: plaintext tracks produce no record at all,
    // an image record holds only the image indicator and vice versa
    wire rec_fire = rec_req && rec_encrypted;

    wire fmc_rec_t next_rec = '{
        valid: rec_fire,
        is_image: rec_fire && rec_image,
        img_present: rec_fire && rec_image,
        img_mark: rec_fire && rec_image && img_on,
        aud_present: rec_fire && !rec_image,
        aud_mark: rec_fire && !rec_image && aud_on
    };

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rec_out <= '0;
        end else begin
            rec_out <= next_rec;
        end
    end

    // Read views
    wire [DATA_W-1:0] ctrl_view = (DATA_W'(staged.nm_img) << CTRL_NM_IMG)
                                | (DATA_W'(staged.nm_aud) << CTRL_NM_AUD)
                                | (DATA_W'(staged.sel) << CTRL_SEL)
                                | (DATA_W'(staged.thr) << CTRL_THR_LSB);

    wire act_img = !active.nm_img;
    wire act_aud = active.sel ? (active.thr != '0) : !active.nm_aud;

    wire [DATA_W-1:0] state_view = (DATA_W'(act_img) << ST_IMG_ON)
                                 | (DATA_W'(act_aud) << ST_AUD_ON)
                                 | (DATA_W'(img_bit) << ST_IMG_BIT)
                                 | (DATA_W'(aud_bit) << ST_AUD_BIT)
                                 | (DATA_W'(active.sel ? active.thr : '0) << ST_THR_LSB);

    // Unmapped addresses read as zero
    wire [DATA_W-1:0] rd_mux = hit_ctrl ? ctrl_view
                             : hit_state ? state_view
                             : hit_time ? DATA_W'(stamp)
                             : hit_loc ? DATA_W'(location)
                             : '0;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? rd_mux : '0;
        end
    end
endmodule

// ===== dv/fmc_mark_ctrl_monitor.sv
`timescale 1ns/1ns
// Port watch on stream timing, bypass and record shape
module fmc_mon (
    input wire logic clock,
    input wire logic arst_n,
    input wire fmc_pkg::fmc_aud_t aud_in,
    input wire fmc_pkg::fmc_aud_t aud_out,
    input wire fmc_pkg::fmc_pix_t pix_in,
    input wire fmc_pkg::fmc_pix_t pix_out,
    input wire logic rec_req,
    input wire logic rec_image,
    input wire logic rec_encrypted,
    input wire fmc_pkg::fmc_rec_t rec_out
);
    import fmc_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Each word leaves once, one cycle on, same channel
    property p_aud_pass;
        aud_in.valid |=> aud_out.valid && aud_out.chan == $past(aud_in.chan);
    endproperty
    a_aud_pass: assert property (p_aud_pass)
        else $error("audio word lost or moved");
    // No word made up out of an idle cycle
    property p_aud_gap;
        !aud_in.valid |=> !aud_out.valid;
    endproperty
    a_aud_gap: assert property (p_aud_gap)
        else $error("audio word inserted");
    // Plaintext audio leaves untouched
    property p_aud_plain;
        aud_in.valid && !aud_in.encrypted |=> aud_out.data == $past(aud_in.data);
    endproperty
    a_aud_plain: assert property (p_aud_plain)
        else $error("plaintext audio altered");
    // Frame start keeps its place in the image stream
    property p_pix_pass;
        pix_in.valid |=> pix_out.valid && pix_out.sof == $past(pix_in.sof);
    endproperty
    a_pix_pass: assert property (p_pix_pass)
        else $error("pixel lost or moved");
    // Plaintext image leaves untouched
    property p_pix_plain;
        pix_in.valid && !pix_in.encrypted |=> pix_out.data == $past(pix_in.data);
    endproperty
    a_pix_plain: assert property (p_pix_plain)
        else $error("plaintext pixel altered");
    // Image record: one image indicator, no audio one
    property p_rec_img;
        rec_req && rec_encrypted && rec_image |=> rec_out.valid && rec_out.is_image
            && rec_out.img_present && !rec_out.aud_present && !rec_out.aud_mark;
    endproperty
    a_rec_img: assert property (p_rec_img)
        else $error("image record malformed");
    // Audio record: one audio indicator, no image one
    property p_rec_aud;
        rec_req && rec_encrypted && !rec_image |=> rec_out.valid && !rec_out.is_image
            && rec_out.aud_present && !rec_out.img_present && !rec_out.img_mark;
    endproperty
    a_rec_aud: assert property (p_rec_aud)
        else $error("audio record malformed");
    // Nothing logged without an encrypted track request
    property p_rec_none;
        !(rec_req && rec_encrypted) |=> rec_out == '0;
    endproperty
    a_rec_none: assert property (p_rec_none)
        else $error("record without encrypted track");
endmodule

bind fmc_mark_ctrl fmc_mon u_mon (.clock(clock), .arst_n(arst_n), .aud_in(aud_in), .aud_out(aud_out),
    .pix_in(pix_in), .pix_out(pix_out), .rec_req(rec_req), .rec_image(rec_image),
    .rec_encrypted(rec_encrypted), .rec_out(rec_out));

// ===== dv/fmc_detect.sv
`timescale 1ns/1ns
// Output chain and detector: compares each output word to its source
module fmc_detect (
    input wire logic clock,
    input wire logic clr,
    input wire fmc_pkg::fmc_aud_t aud_in,
    input wire fmc_pkg::fmc_aud_t aud_out,
    input wire fmc_pkg::fmc_pix_t pix_in,
    input wire fmc_pkg::fmc_pix_t pix_out,
    output logic [fmc_pkg::NCH-1:0] aud_hit,
    output logic img_hit,
    output logic plain_hit
);
    import fmc_pkg::*;
    fmc_aud_t a_q;
    fmc_pix_t p_q;
    // Source held one word so it lines up with the registered output
    always @(posedge clock) begin
        a_q <= aud_in;
        p_q <= pix_in;
        if (clr) begin
            aud_hit <= '0;
            img_hit <= 1'b0;
            plain_hit <= 1'b0;
        end else begin
            if (aud_out.valid && aud_out.data !== a_q.data) begin
                if (a_q.encrypted)
                    aud_hit[aud_out.chan] <= 1'b1;
                else
                    plain_hit <= 1'b1;
            end
            if (pix_out.valid && pix_out.data !== p_q.data) begin
                if (p_q.encrypted)
                    img_hit <= 1'b1;
                else
                    plain_hit <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ns
// Self-checking bench for the mark controller
module tb;
    import fmc_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic comp_start = 1'b0;
    logic rec_req = 1'b0;
    logic rec_image = 1'b0;
    logic rec_encrypted = 1'b0;
    logic [DATA_W-1:0] rdata;
    fmc_aud_t aud_in = '0;
    fmc_aud_t aud_out;
    fmc_pix_t pix_in = '0;
    fmc_pix_t pix_out;
    fmc_rec_t rec_out;
    logic [NCH-1:0] aud_hit;
    logic img_hit;
    logic plain_hit;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00000017;
    logic [31:0] t;
    // Flag words per composition: none, image, sound, both, selective 6/8/17/0
    logic [15:0] ctab [0:8] = '{16'h0003, 16'h0002, 16'h0001, 16'h0000, 16'h0606,
        16'h0805, 16'h1104, 16'h0004, 16'h0000};

    always #2 clock = ~clock;

    // Small counts so a full payload pass fits in a short run
    fmc_mark_ctrl #(.QTR_CYCLES(20), .SAMPLES_PER_BIT(2), .FRAMES_PER_BIT(2)) uut (
        .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .comp_start(comp_start), .aud_in(aud_in), .aud_out(aud_out),
        .pix_in(pix_in), .pix_out(pix_out), .rec_req(rec_req), .rec_image(rec_image),
        .rec_encrypted(rec_encrypted), .rec_out(rec_out));

    fmc_detect u_det (.clock(clock), .clr(comp_start | !arst_n), .aud_in(aud_in),
        .aud_out(aud_out), .pix_in(pix_in), .pix_out(pix_out), .aud_hit(aud_hit),
        .img_hit(img_hit), .plain_hit(plain_hit));

    // Xorshift, fixed start
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Channels expected to carry a mark under one flag word
    function automatic logic [NCH-1:0] exp_mask(logic [15:0] c);
        logic on;
        logic [NCH-1:0] m;
        on = c[2] ? (c[14:8] != 7'h00) : !c[1];
        for (int i = 0; i < NCH; i++)
            m[i] = on && (!c[2] || i < c[14:8]);
        return m;
    endfunction

    task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d of %0d checks", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data sampled mid-cycle, its only valid cycle; mask hides live mark bits
    task automatic rd_reg(logic [7:0] a, logic [31:0] e, string nm, logic [31:0] m = 32'hffffffff);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        check(nm, rdata & m, e);
        @(posedge clock);
    endtask

    task automatic rec(logic img, logic enc, fmc_rec_t e);
        rec_req <= 1'b1;
        rec_image <= img;
        rec_encrypted <= enc;
        @(posedge clock);
        rec_req <= 1'b0;
        @(negedge clock);
        check("rec", rec_out, e);
        @(posedge clock);
    endtask

    // Back-to-back frames of 16 words, random data and encryption
    task automatic stream(int frames);
        logic [31:0] r;
        for (int f = 0; f < frames; f++) begin
            for (int c = 0; c < NCH; c++) begin
                r = rnd();
                aud_in <= '{1'b1, r[1:0] != 2'b00, CH_W'(c), r[31:8]};
                pix_in <= '{1'b1, c == 0, r[3:2] != 2'b00, {r[31:4], r[7:0]}};
                @(posedge clock);
            end
        end
        aud_in <= '0;
        pix_in <= '0;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        wr_reg(REG_LOC, 32'hffffffff);
        rd_reg(REG_LOC, 32'h0007ffff, "loc");
        t = rnd() % TS_VALUES;
        wr_reg(REG_TIME, t);
        rd_reg(REG_TIME, t, "time");
        wr_reg(REG_TIME, 32'h00008940);
        rd_reg(REG_TIME, 32'h00000000, "time_over");
        wr_reg(REG_TIME, 32'h0000893f);
        rd_reg(REG_TIME, 32'h0000893f, "time_last");
        repeat (20) @(posedge clock);
        rd_reg(REG_TIME, 32'h00000000, "time_wrap");
        rd_reg(8'h10, 32'h00000000, "unmapped");
        wr_reg(REG_CTRL, {16'h0000, ctab[0]});
        // One composition per flag word; next word staged mid-run
        for (int i = 0; i < 8; i++) begin
            comp_start <= 1'b1;
            @(posedge clock);
            comp_start <= 1'b0;
            stream(60);
            wr_reg(REG_CTRL, {16'h0000, ctab[i + 1]});
            wr_reg(REG_STATE, 32'h00000003);
            stream(60);
            check("aud_mask", aud_hit, exp_mask(ctab[i]));
            check("img_mark", img_hit, !ctab[i][0]);
            check("plain", plain_hit, 1'b0);
            // Mark bits 3:2 move with the payload, so only enables and threshold are compared
            rd_reg(REG_STATE, {17'h0, (ctab[i][2] ? ctab[i][14:8] : 7'h00), 6'h0,
                |exp_mask(ctab[i]), !ctab[i][0]}, "state", 32'h00007f03);
            rec(1'b1, 1'b1, '{1'b1, 1'b1, 1'b1, !ctab[i][0], 1'b0, 1'b0});
            rec(1'b0, 1'b1, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, |exp_mask(ctab[i])});
            rec(1'b0, 1'b0, '0);
        end
        wrap_up();
    end
endmodule
